/* cbs_params.svh */
// Constants of the bus cycle sequencer: addresses, cycle counts, timing.
`ifndef CBS_PARAMS_SVH
`define CBS_PARAMS_SVH
`define CBS_DUMMY_ADDR     16'hffff
`define CBS_TRAP_VEC_HI    16'hfffa
`define CBS_TRAP_VEC_LO    16'hfffb
`define CBS_WAIT_OFS       16'h0007
`define CBS_INT_LO         16'h0000
`define CBS_INT_HI         16'h00ff
`define CBS_E_PERIOD_NS    1000
`define CBS_CLK_PERIOD_NS  25
`define CBS_E_DIV          (`CBS_E_PERIOD_NS / `CBS_CLK_PERIOD_NS)
`define CBS_LEN_2          4'h2
`define CBS_LEN_3          4'h3
`define CBS_LEN_4          4'h4
`define CBS_LEN_5          4'h5
`define CBS_LEN_6          4'h6
`define CBS_LEN_9          4'h9
`define CBS_LEN_10         4'ha
`define CBS_LEN_12         4'hc
`define CBS_STACK_LAST     4'h9
`endif

/* cbs_pkg.sv */
// Types shared by the bus cycle sequencer modules.
package cbs_pkg;
  typedef enum logic [4:0] {
    CLS_IDX_RD, CLS_IDX_WR, CLS_IDX_JMP, CLS_IDX_LD16, CLS_IDX_ST16,
    CLS_IDX_RMW, CLS_IDX_TST, CLS_EXT_RMW, CLS_EXT_TST, CLS_IDX_CMP16,
    CLS_IDX_CALL, CLS_EXT_CALL, CLS_IMPL2, CLS_IMPL3, CLS_MUL,
    CLS_PUSH_ACC, CLS_PUSH_X, CLS_PULL_ACC, CLS_PULL_X, CLS_RTS,
    CLS_WAI, CLS_RTI, CLS_SWI, CLS_BRA, CLS_BSR
  } cbs_class_t;

  typedef struct packed {
    cbs_class_t  cls;
    logic [15:0] pc;
    logic [15:0] idx;
    logic [15:0] sp;
    logic [15:0] ea;
    logic [7:0]  offset;
    logic [7:0]  acc_a;
    logic [7:0]  acc_b;
    logic [7:0]  ccr;
    logic [15:0] wr;
  } cbs_op_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rw;
    logic [7:0]  data;
    logic        data_oe;
  } cbs_bus_t;
endpackage

/* cbs_ediv.sv */
// Machine cycle divider: one-cycle enable every DIV core clocks.
`timescale 1ns/1ps
`default_nettype none
`include "cbs_params.svh"
module cbs_ediv #(
  parameter int DIV = `CBS_E_DIV
) (
  input  wire logic core_clk_in,  // Core clock.
  input  wire logic nrst_in,      // Asynchronous reset, active low.
  output logic      e_en_out      // Machine cycle enable pulse.
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // Wrap the count at DIV-1; the enable marks the wrap.
  always_comb begin
    e_en_out = (cnt_ff == W'(DIV - 1));
    nxt_cnt  = e_en_out ? '0 : cnt_ff + W'(1);
  end

  // Count register.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule
`default_nettype wire

/* cbs_len_lut.sv */
// Cycle count of each instruction class.
`timescale 1ns/1ps
`default_nettype none
`include "cbs_params.svh"
module cbs_len_lut (
  input  wire cbs_pkg::cbs_class_t cls_in,  // Instruction class.
  output logic [3:0]               len_out  // Machine cycles it takes.
);
  import cbs_pkg::*;

  // Classes sharing a length are grouped.
  always_comb begin
    case (cls_in)
      CLS_IMPL2:                                len_out = `CBS_LEN_2;
      CLS_IDX_JMP, CLS_IMPL3, CLS_BRA,
      CLS_PUSH_ACC:                             len_out = `CBS_LEN_3;
      CLS_IDX_RD, CLS_IDX_WR, CLS_PUSH_X,
      CLS_PULL_ACC:                             len_out = `CBS_LEN_4;
      CLS_IDX_LD16, CLS_IDX_ST16, CLS_PULL_X,
      CLS_RTS:                                  len_out = `CBS_LEN_5;
      CLS_WAI:                                  len_out = `CBS_LEN_9;
      CLS_MUL, CLS_RTI:                         len_out = `CBS_LEN_10;
      CLS_SWI:                                  len_out = `CBS_LEN_12;
      default:                                  len_out = `CBS_LEN_6;
    endcase
  end
endmodule
`default_nettype wire

/* cbs_seq.sv */
// Bus cycle sequencer: address, read/write and data for each machine cycle.
`timescale 1ns/1ps
`default_nettype none
`include "cbs_params.svh"
module cbs_seq #(
  parameter int E_DIV = `CBS_E_DIV
) (
  input  wire logic             core_clk_in,   // Core clock, 40 MHz.
  input  wire logic             nrst_in,       // Asynchronous reset, low.
  input  wire logic             start_in,      // Instruction request.
  input  wire cbs_pkg::cbs_op_t op_in,         // Instruction and registers.
  input  wire logic             wake_in,       // Leaves the wait state.
  input  wire logic             mode0_in,      // Device runs in mode 0.
  input  wire logic [7:0]       int_rdata_in,  // On-chip read value.
  output logic                  ready_out,     // Request can be taken this clock.
  output logic                  done_out,      // Instruction ends, pulse.
  output logic                  e_en_out,      // Machine cycle boundary.
  output logic [3:0]            cyc_out,       // Current cycle number.
  output logic                  halted_out,    // In the wait state.
  output logic [15:0]           addr_lines_out,// Address bus.
  output logic                  rw_out,        // High read, low write.
  output logic [7:0]            data_lines_out,// Data bus value.
  output logic                  data_oe_out    // Data bus driven.
);
  import cbs_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT} cbs_state_t;

  localparam cbs_bus_t IDLE_BUS = '{addr: `CBS_DUMMY_ADDR, rw: 1'b1,
                                    data: 8'h00, data_oe: 1'b0};

  cbs_state_t state_ff;
  cbs_state_t nxt_state;
  logic [3:0] cyc_ff;
  logic [3:0] nxt_cyc;
  cbs_op_t    op_ff;
  cbs_op_t    nxt_op;
  cbs_bus_t   bus_ff;
  cbs_bus_t   nxt_bus;
  logic [3:0] len;
  logic       e_en;
  logic       last;
  logic       fin;
  logic       int_hit;

  cbs_ediv #(.DIV(E_DIV)) u_ediv (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .e_en_out    (e_en)
  );

  cbs_len_lut u_len (
    .cls_in  (op_ff.cls),
    .len_out (len)
  );

  // Bus content of cycle c of instruction o; cycles 1 and 2 are common.
  function automatic cbs_bus_t bus_of(cbs_op_t o, logic [3:0] c,
                                      logic halt);
    cbs_bus_t    b;
    logic [15:0] ix;
    logic [15:0] ret;
    logic [15:0] tgt;
    logic [7:0]  stk [0:6];
    logic [3:0]  k;
    logic        ext;
    ix  = o.idx + {8'h00, o.offset};
    ext = (o.cls == CLS_EXT_RMW) || (o.cls == CLS_EXT_TST) ||
          (o.cls == CLS_EXT_CALL);
    case (o.cls)
      CLS_EXT_CALL: ret = o.pc + 16'h0003;
      CLS_IDX_CALL, CLS_BSR: ret = o.pc + 16'h0002;
      default: ret = o.pc + 16'h0001;
    endcase
    case (o.cls)
      CLS_EXT_CALL: tgt = o.ea;
      CLS_BSR: tgt = ret + {{8{o.offset[7]}}, o.offset};
      default: tgt = ix;
    endcase
    stk[0] = ret[7:0];
    stk[1] = ret[15:8];
    stk[2] = o.idx[7:0];
    stk[3] = o.idx[15:8];
    stk[4] = o.acc_a;
    stk[5] = o.acc_b;
    stk[6] = o.ccr;
    k = c - 4'h3;
    b = IDLE_BUS;
    if (halt) begin
      b.addr = o.sp - `CBS_WAIT_OFS;
    end else if (c == 4'h1) begin
      b.addr = o.pc;
    end else if (c == 4'h2) begin
      b.addr = o.pc + 16'h0001;
    end else if (ext && (c == 4'h3)) begin
      b.addr = o.pc + 16'h0002;
    end else begin
      // Anything not listed below stays the FFFF dummy read.
      case (o.cls)
        CLS_IDX_RD, CLS_IDX_LD16, CLS_IDX_CMP16: begin
          if (c == 4'h4) begin
            b.addr = ix;
          end else if ((c == 4'h5) && (o.cls != CLS_IDX_RD)) begin
            b.addr = ix + 16'h0001;
          end
        end
        CLS_IDX_WR: begin
          if (c == 4'h4) begin
            b.addr = ix;
            b.rw   = 1'b0;
            b.data = o.wr[7:0];
          end
        end
        CLS_IDX_ST16: begin
          if (c == 4'h4 || c == 4'h5) begin
            b.addr = (c == 4'h4) ? ix : ix + 16'h0001;
            b.rw   = 1'b0;
            b.data = (c == 4'h4) ? o.wr[15:8] : o.wr[7:0];
          end
        end
        CLS_IDX_RMW, CLS_IDX_TST, CLS_EXT_RMW, CLS_EXT_TST: begin
          if (c == 4'h4) begin
            b.addr = ext ? o.ea : ix;
          end else if ((c == 4'h6) && (o.cls == CLS_IDX_RMW ||
                                        o.cls == CLS_EXT_RMW)) begin
            b.addr = ext ? o.ea : ix;
            b.rw   = 1'b0;
            b.data = o.wr[7:0];
          end
        end
        CLS_IDX_CALL, CLS_EXT_CALL, CLS_BSR: begin
          if (c == 4'h4) begin
            b.addr = tgt;
          end else if (c == 4'h5 || c == 4'h6) begin
            b.addr = (c == 4'h5) ? o.sp : o.sp - 16'h0001;
            b.rw   = 1'b0;
            b.data = (c == 4'h5) ? ret[7:0] : ret[15:8];
          end
        end
        CLS_PUSH_ACC: begin
          if (c == 4'h3) begin
            b.addr = o.sp;
            b.rw   = 1'b0;
            b.data = o.wr[7:0];
          end
        end
        CLS_PUSH_X: begin
          if (c == 4'h3 || c == 4'h4) begin
            b.addr = o.sp + {12'h000, k};
            b.rw   = 1'b0;
            b.data = (c == 4'h3) ? o.idx[7:0] : o.idx[15:8];
          end
        end
        CLS_PULL_ACC, CLS_PULL_X, CLS_RTS, CLS_RTI: begin
          b.addr = o.sp + {12'h000, k};
        end
        CLS_WAI, CLS_SWI: begin
          if (c <= `CBS_STACK_LAST) begin
            b.addr = o.sp - {12'h000, k};
            b.rw   = 1'b0;
            b.data = stk[k[2:0]];
          end else if (c == 4'ha) begin
            b.addr = o.sp - `CBS_WAIT_OFS;
          end else if (c == 4'hb) begin
            b.addr = `CBS_TRAP_VEC_HI;
          end else begin
            b.addr = `CBS_TRAP_VEC_LO;
          end
        end
        default: begin
          b.addr = `CBS_DUMMY_ADDR;
        end
      endcase
    end
    b.data_oe = ~b.rw;
    return b;
  endfunction

  // Sequencing: a request is taken on a cycle boundary when idle or when
  // the running instruction ends, so instructions run back to back.
  always_comb begin
    nxt_state = state_ff;
    nxt_cyc   = cyc_ff;
    nxt_op    = op_ff;
    last      = (cyc_ff == len);
    fin       = e_en && (((state_ff == ST_RUN) && last &&
                          (op_ff.cls != CLS_WAI)) ||
                         ((state_ff == ST_HALT) && wake_in));
    ready_out = e_en && ((state_ff == ST_IDLE) || fin);
    if (e_en) begin
      case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_IDLE;
        end
        ST_RUN: begin
          if (!last) begin
            nxt_cyc = cyc_ff + 4'h1;
          end else if (op_ff.cls == CLS_WAI) begin
            nxt_state = ST_HALT;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
        ST_HALT: begin
          if (wake_in) begin
            nxt_state = ST_IDLE;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
    if (ready_out && start_in) begin
      nxt_state = ST_RUN;
      nxt_cyc   = 4'h1;
      nxt_op    = op_in;
    end
    // Halt keeps address and read/write driven; the data drivers are off.
    nxt_bus = (nxt_state == ST_IDLE) ? IDLE_BUS :
              bus_of(nxt_op, nxt_cyc, nxt_state == ST_HALT);
  end

  // State registers; the bus is registered with the state it belongs to.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= ST_IDLE;
      cyc_ff   <= 4'h0;
      op_ff    <= '0;
      bus_ff   <= IDLE_BUS;
    end else begin
      state_ff <= nxt_state;
      cyc_ff   <= nxt_cyc;
      op_ff    <= nxt_op;
      bus_ff   <= nxt_bus;
    end
  end

  // On-chip reads reach the pins only in mode 0; the value comes from the
  // core as it is read, so this path is combinational.
  assign int_hit        = bus_ff.rw && (bus_ff.addr >= `CBS_INT_LO) &&
                          (bus_ff.addr <= `CBS_INT_HI);
  assign data_oe_out    = bus_ff.data_oe || (mode0_in && int_hit);
  assign data_lines_out = (mode0_in && int_hit) ? int_rdata_in :
                          bus_ff.data;
  assign addr_lines_out = bus_ff.addr;
  assign rw_out         = bus_ff.rw;
  assign done_out       = fin;
  assign e_en_out       = e_en;
  assign cyc_out        = cyc_ff;
  assign halted_out     = (state_ff == ST_HALT);

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  logic run;
  assign run = (state_ff == ST_RUN);

  property p_idx_dummy;
    run && cyc_ff == 4'h3 && (op_ff.cls == CLS_IDX_RD ||
      op_ff.cls == CLS_IDX_JMP || op_ff.cls == CLS_IDX_WR)
      |-> addr_lines_out == `CBS_DUMMY_ADDR && rw_out;
  endproperty
  a_idx_dummy: assert property (p_idx_dummy)
    else $error("indexed third cycle is not a dummy read");

  property p_st16_low;
    run && cyc_ff == 4'h5 && op_ff.cls == CLS_IDX_ST16 |->
      addr_lines_out == op_ff.idx + {8'h00, op_ff.offset} + 16'h0001 &&
      !rw_out && data_lines_out == op_ff.wr[7:0];
  endproperty
  a_st16_low: assert property (p_st16_low)
    else $error("16-bit store low byte wrong");

  property p_tst_nowrite;
    run && cyc_ff == 4'h6 && op_ff.cls == CLS_IDX_TST |->
      rw_out && addr_lines_out == `CBS_DUMMY_ADDR;
  endproperty
  a_tst_nowrite: assert property (p_tst_nowrite)
    else $error("test operand wrote in cycle 6");

  property p_mul_dummy;
    run && op_ff.cls == CLS_MUL && cyc_ff >= 4'h3 |->
      addr_lines_out == `CBS_DUMMY_ADDR && rw_out;
  endproperty
  a_mul_dummy: assert property (p_mul_dummy)
    else $error("multiply internal cycle not a dummy read");

  property p_wai_stack;
    run && op_ff.cls == CLS_WAI && cyc_ff >= 4'h3 |->
      !rw_out && addr_lines_out == op_ff.sp - {12'h000, cyc_ff - 4'h3};
  endproperty
  a_wai_stack: assert property (p_wai_stack)
    else $error("wait stacking address wrong");

  property p_halt_read;
    halted_out |-> rw_out && addr_lines_out == op_ff.sp - `CBS_WAIT_OFS;
  endproperty
  a_halt_read: assert property (p_halt_read)
    else $error("wait state read address wrong");

  property p_trap_vec;
    run && op_ff.cls == CLS_SWI && cyc_ff == 4'hb && e_en |=>
      addr_lines_out == `CBS_TRAP_VEC_LO && $past(addr_lines_out) ==
      `CBS_TRAP_VEC_HI;
  endproperty
  a_trap_vec: assert property (p_trap_vec)
    else $error("trap vector fetch order wrong");

  property p_rti_last;
    run && op_ff.cls == CLS_RTI && cyc_ff == 4'ha |->
      rw_out && addr_lines_out == op_ff.sp + 16'h0007;
  endproperty
  a_rti_last: assert property (p_rti_last)
    else $error("trap return last read address wrong");

  property p_write_drives;
    !rw_out |-> data_oe_out;
  endproperty
  a_write_drives: assert property (p_write_drives)
    else $error("write cycle without data drive");

  property p_start_fetch;
    ready_out && start_in |=> cyc_out == 4'h1 && rw_out &&
      addr_lines_out == $past(op_in.pc);
  endproperty
  a_start_fetch: assert property (p_start_fetch)
    else $error("first cycle is not the opcode fetch");
endmodule
`default_nettype wire

/* cbs_mem_model.sv */
// Bus partner: logs each machine cycle of a taken instruction and supplies on-chip read data.
`timescale 1ns/1ps
`default_nettype none
module cbs_mem_model (
  input  wire logic              core_clk_in,   // Core clock.
  input  wire logic              nrst_in,       // Reset, active low.
  input  wire logic              e_en_in,       // Machine cycle boundary.
  input  wire logic              take_in,       // Request taken this clock.
  input  wire logic              done_in,       // Instruction ends.
  input  wire cbs_pkg::cbs_bus_t bus_in,        // Bus seen at the pins.
  output logic [7:0]             int_rdata_out  // On-chip read value.
);
  import cbs_pkg::*;
  cbs_bus_t log [$];
  logic     busy;

  // Each on-chip address holds a different value, so a stale mirror shows up.
  assign int_rdata_out = ~bus_in.addr[7:0];

  // A cycle is logged at the edge that ends it, so the bus is still settled.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy <= 1'b0;
    end else begin
      if (e_en_in && busy) begin
        log.push_back(bus_in);
      end
      busy <= take_in | (busy & ~done_in);
    end
  end
endmodule
`default_nettype wire

/* cpu_bus_cycle_sequencer_bench.sv */
// Self-checking bench of the bus cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_cycle_sequencer_bench;
  import cbs_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  logic        start    = 1'b0;
  logic        wake     = 1'b0;
  logic        mode0    = 1'b0;
  cbs_op_t     op       = '0;
  logic        ready, done, e_en, halted, rw, oe;
  logic [3:0]  cyc;
  logic [15:0] addr;
  logic [7:0]  rdata, data;
  cbs_bus_t    bus;
  int          bad_count = 0;
  int          checked   = 0;

  // Two clocks per machine cycle keep the run short.
  cbs_seq #(.E_DIV(2)) i_cbs_seq (
    .core_clk_in(core_clk), .nrst_in(nrst), .start_in(start),
    .op_in(op), .wake_in(wake), .mode0_in(mode0), .int_rdata_in(rdata),
    .ready_out(ready), .done_out(done), .e_en_out(e_en), .cyc_out(cyc),
    .halted_out(halted), .addr_lines_out(addr), .rw_out(rw),
    .data_lines_out(data), .data_oe_out(oe));
  assign bus = {addr, rw, data, oe};
  cbs_mem_model i_cbs_mem_model (
    .core_clk_in(core_clk), .nrst_in(nrst), .e_en_in(e_en),
    .take_in(start & ready), .done_in(done), .bus_in(bus),
    .int_rdata_out(rdata));

  // Free-running 40 MHz clock.
  always #12.5 core_clk = ~core_clk;

  task automatic fail(string m);
    bad_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk_bit(logic g, logic e, string m);
    checked++;
    if (g !== e) fail(m);
  endtask

  task automatic chk_bus(int k, cbs_bus_t e);
    cbs_bus_t g;
    checked++;
    if (k >= i_cbs_mem_model.log.size()) begin
      fail($sformatf("cycle %0d missing", k + 1));
      return;
    end
    g = i_cbs_mem_model.log[k];
    if (g.addr !== e.addr || g.rw !== e.rw || g.data_oe !== e.data_oe ||
        (e.data_oe && g.data !== e.data)) begin
      fail($sformatf("cycle %0d bus %h want %h", k + 1, g, e));
    end
  endtask

  function automatic cbs_bus_t rd(logic [15:0] a);
    return {a, 1'b1, 8'h00, 1'b0};
  endfunction

  function automatic cbs_bus_t wr8(logic [15:0] a, logic [7:0] d);
    return {a, 1'b0, d, 1'b1};
  endfunction

  function automatic cbs_op_t mk(cbs_class_t c);
    return '{c, 16'h2100, 16'h3000, 16'h4f80, 16'h6123, 8'h85, 8'h11,
             8'h22, 8'hc5, 16'hbe37};
  endfunction

  // Expected pins in cycle c of op o, worked out from the cycle tables.
  function automatic cbs_bus_t exp_bus(cbs_op_t o, int c);
    logic [15:0] ix, ret, oa, tg;
    logic [55:0] stk;
    cbs_bus_t    r;
    ix  = o.idx + {8'h00, o.offset};
    ret = o.pc + 16'h0002;
    if (o.cls == CLS_EXT_CALL) ret = o.pc + 16'h0003;
    if (o.cls inside {CLS_WAI, CLS_SWI}) ret = o.pc + 16'h0001;
    oa  = (o.cls inside {CLS_EXT_RMW, CLS_EXT_TST}) ? o.ea : ix;
    tg  = (o.cls == CLS_EXT_CALL) ? o.ea : ix;
    if (o.cls == CLS_BSR) tg = o.pc + 16'h0002 + {{8{o.offset[7]}}, o.offset};
    stk = {o.ccr, o.acc_b, o.acc_a, o.idx, ret};
    r   = rd(16'hffff);
    if (c < 3) r = rd(o.pc + 16'(c - 1));
    else if (c == 3 && o.cls inside {CLS_EXT_RMW, CLS_EXT_TST, CLS_EXT_CALL})
      r = rd(o.pc + 16'h0002);
    else case (o.cls)
      CLS_IDX_RD, CLS_IDX_LD16, CLS_IDX_CMP16: begin
        if (c > 3 && c < 6) r = rd(ix + 16'(c - 4));
      end
      CLS_IDX_WR: if (c == 4) r = wr8(ix, o.wr[7:0]);
      CLS_IDX_ST16: begin
        if (c > 3) r = wr8(ix + 16'(c - 4), c == 4 ? o.wr[15:8] : o.wr[7:0]);
      end
      CLS_IDX_RMW, CLS_IDX_TST, CLS_EXT_RMW, CLS_EXT_TST: begin
        if (c == 4) r = rd(oa);
        if (c == 6 && o.cls inside {CLS_IDX_RMW, CLS_EXT_RMW})
          r = wr8(oa, o.wr[7:0]);
      end
      CLS_IDX_CALL, CLS_EXT_CALL, CLS_BSR: begin
        if (c == 4) r = rd(tg);
        if (c > 4) r = wr8(o.sp - 16'(c - 5), ret[8*(c-5) +: 8]);
      end
      CLS_PUSH_ACC: r = wr8(o.sp, o.wr[7:0]);
      CLS_PUSH_X: r = wr8(o.sp + 16'(c - 3), o.idx[8*(c-3) +: 8]);
      CLS_PULL_ACC, CLS_PULL_X, CLS_RTS, CLS_RTI: r = rd(o.sp + 16'(c - 3));
      CLS_WAI, CLS_SWI: begin
        if (c < 10) r = wr8(o.sp - 16'(c - 3), stk[8*(c-3) +: 8]);
        else if (o.cls == CLS_WAI || c == 10) r = rd(o.sp - 16'h0007);
        else r = rd(c == 11 ? 16'hfffa : 16'hfffb);
      end
      default: ;
    endcase
    // On-chip reads reach the pins only in mode 0.
    if (mode0 && r.rw && r.addr <= 16'h00ff) begin
      r.data_oe = 1'b1;
      r.data = ~r.addr[7:0];
    end
    return r;
  endfunction

  // The request is held until a clock with ready takes it.
  task automatic issue(cbs_op_t o);
    int k;
    k = 0;
    op = o;
    start = 1'b1;
    while (ready !== 1'b1 && k < 200) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    @(posedge core_clk);
    #1;
    start = 1'b0;
    if (k >= 200) fail("request not taken");
  endtask

  // Edge lets the model log the final cycle; omitted for back to back.
  task automatic poll_done(bit edge_after);
    int k;
    k = 0;
    while (done !== 1'b1 && k < 400) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= 400) fail("no completion");
    if (edge_after) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic run(cbs_op_t o, int n);
    i_cbs_mem_model.log.delete();
    issue(o);
    poll_done(1'b1);
    chk_bit(i_cbs_mem_model.log.size() == n, 1'b1, "cycle count");
    chk_bit(cyc === 4'(n), 1'b1, "last cycle number");
    for (int c = 1; c <= n; c++) chk_bus(c - 1, exp_bus(o, c));
  endtask

  task automatic t_indexed;
    run(mk(CLS_IDX_RD), 4);
    run(mk(CLS_IDX_WR), 4);
    run(mk(CLS_IDX_JMP), 3);
    run(mk(CLS_IDX_LD16), 5);
    run(mk(CLS_IDX_ST16), 5);
    run(mk(CLS_IDX_RMW), 6);
    run(mk(CLS_IDX_TST), 6);
    run(mk(CLS_EXT_RMW), 6);
    run(mk(CLS_EXT_TST), 6);
    run(mk(CLS_IDX_CMP16), 6);
    run(mk(CLS_IDX_CALL), 6);
    run(mk(CLS_EXT_CALL), 6);
  endtask

  task automatic t_implied;
    run(mk(CLS_IMPL2), 2);
    run(mk(CLS_IMPL3), 3);
    run(mk(CLS_MUL), 10);
    run(mk(CLS_PUSH_ACC), 3);
    run(mk(CLS_PUSH_X), 4);
    run(mk(CLS_PULL_ACC), 4);
    run(mk(CLS_PULL_X), 5);
    run(mk(CLS_RTS), 5);
    run(mk(CLS_RTI), 10);
    run(mk(CLS_SWI), 12);
    run(mk(CLS_BRA), 3);
    run(mk(CLS_BSR), 6);
  endtask

  // Three wait-state cycles are seen before the wake request.
  task automatic t_wait;
    int k;
    k = 0;
    i_cbs_mem_model.log.delete();
    issue(mk(CLS_WAI));
    while (i_cbs_mem_model.log.size() < 12 && k < 100) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk_bit(halted, 1'b1, "not halted");
    for (int c = 1; c <= 12; c++) begin
      chk_bus(c - 1, exp_bus(mk(CLS_WAI), c));
    end
    wake = 1'b1;
    poll_done(1'b1);
    wake = 1'b0;
    chk_bit(halted, 1'b0, "still halted");
  endtask

  // Operand pair straddles the end of the on-chip region.
  task automatic t_mirror;
    cbs_op_t o;
    o = mk(CLS_IDX_LD16);
    o.idx = 16'h0000;
    o.offset = 8'hff;
    mode0 = 1'b1;
    run(o, 5);
    mode0 = 1'b0;
    run(o, 5);
  endtask

  task automatic t_b2b;
    i_cbs_mem_model.log.delete();
    issue(mk(CLS_BRA));
    poll_done(1'b0);
    issue(mk(CLS_PUSH_ACC));
    poll_done(1'b1);
    for (int c = 1; c <= 3; c++) begin
      chk_bus(c - 1, exp_bus(mk(CLS_BRA), c));
      chk_bus(c + 2, exp_bus(mk(CLS_PUSH_ACC), c));
    end
  endtask

  // Reset in mid-instruction must return the bus to an idle read.
  task automatic t_reset;
    issue(mk(CLS_MUL));
    repeat (5) @(posedge core_clk);
    #1;
    nrst = 1'b0;
    #5;
    chk_bit(addr === 16'hffff, 1'b1, "reset address");
    chk_bit(rw, 1'b1, "reset read line");
    chk_bit(oe, 1'b0, "reset data drive");
    chk_bit(cyc === 4'h0, 1'b1, "reset cycle number");
    @(posedge core_clk);
    #1;
    nrst = 1'b1;
    run(mk(CLS_IMPL2), 2);
  endtask

  task automatic give_verdict;
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    t_indexed;
    t_implied;
    t_wait;
    t_mirror;
    t_b2b;
    t_reset;
    give_verdict;
  end

  // About thirty short instructions need under 20 us; 400 us is ample.
  initial begin
    #400000;
    fail("watchdog expired");
    give_verdict;
  end
endmodule
`default_nettype wire
